/* File: rtl/ssrl_pkg.sv */
// Overview of operation
// - six relay outputs, each with its own function code register
// - ramp-complete output latches after ramp ends, ignores later load dips
// - at-setpoint output follows speed inside the tolerance band
// - torque output set when torque magnitude below threshold, not while accelerating
// - speed outputs set below minimum speed or general threshold, separate settings
// - motor prewarn output drops on overtemperature; rising temperature faults after delay
// - heatsink prewarn output drops on switch; twenty seconds later fault and shutdown
// - variable monitor shows a selected internal variable, on two relays only
// - in-position outputs set after positioning inside window one or two
// - star and delta outputs drive the external winding contactor
// - minimum speed, temperature and monitor codes only in fine axis mode
// - controller enable removed: ramp braking, pulses off below minimum speed
// - fast stop removed: torque limit braking, then pulses off or stay magnetized
// - fault reset clears only after cause gone and controller enable inactive
package ssrl_pkg;

  localparam int unsigned NUM_RELAYS     = 6;
  localparam int unsigned NUM_VAR_RELAYS = 2;

  // timebase
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned TICK_TIME_NS     = 1000000;
  localparam int unsigned TICK_CYCLES_DEF  = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HS_DELAY_S       = 20;
  localparam int unsigned HS_DELAY_TICKS   = HS_DELAY_S * (1000000000 / TICK_TIME_NS);

  // register byte offsets
  localparam logic [6:0] REG_RELAY_FUNC0 = 7'h00;
  localparam logic [6:0] REG_SPEED_TOL   = 7'h18;
  localparam logic [6:0] REG_TORQUE_THR  = 7'h1C;
  localparam logic [6:0] REG_SPEED_MIN   = 7'h20;
  localparam logic [6:0] REG_SPEED_X     = 7'h24;
  localparam logic [6:0] REG_INPOS_WIN1  = 7'h28;
  localparam logic [6:0] REG_INPOS_WIN2  = 7'h2C;
  localparam logic [6:0] REG_CTRL        = 7'h30;
  localparam logic [6:0] REG_MT_DELAY    = 7'h34;
  localparam logic [6:0] REG_STATUS      = 7'h38;
  localparam logic [6:0] REG_IRQ_STAT    = 7'h3C;
  localparam logic [6:0] REG_IRQ_MASK    = 7'h40;

  // control register fields
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned CTRL_VSEL_LSB = 4;

  // reset values
  localparam logic [15:0] RST_SPEED_TOL  = 16'h0010;
  localparam logic [15:0] RST_TORQUE_THR = 16'h0100;
  localparam logic [15:0] RST_SPEED_MIN  = 16'h0008;
  localparam logic [15:0] RST_SPEED_X    = 16'h0040;
  localparam logic [15:0] RST_INPOS_WIN  = 16'h0004;
  localparam logic [15:0] RST_MT_DELAY   = 16'h03E8;

  // interrupt event bits
  localparam int unsigned IRQ_MT_WARN  = 0;
  localparam int unsigned IRQ_HS_WARN  = 1;
  localparam int unsigned IRQ_MT_FAULT = 2;
  localparam int unsigned IRQ_HS_FAULT = 3;
  localparam int unsigned IRQ_W        = 4;

  typedef enum logic [3:0] {
    SSRL_FN_NONE     = 4'h0,
    SSRL_FN_RAMP     = 4'h1,
    SSRL_FN_AT_SET   = 4'h2,
    SSRL_FN_TORQUE   = 4'h3,
    SSRL_FN_NMIN     = 4'h4,
    SSRL_FN_NX       = 4'h5,
    SSRL_FN_MT_WARN  = 4'h6,
    SSRL_FN_HS_WARN  = 4'h7,
    SSRL_FN_VAR      = 4'h8,
    SSRL_FN_INPOS1   = 4'h9,
    SSRL_FN_INPOS2   = 4'hA,
    SSRL_FN_STAR     = 4'hB,
    SSRL_FN_DELTA    = 4'hC
  } ssrl_func_t;

  typedef enum logic [2:0] {
    SSRL_DRV_OFF     = 3'b000,
    SSRL_DRV_RUN     = 3'b001,
    SSRL_DRV_RAMP_BR = 3'b010,
    SSRL_DRV_TQ_BR   = 3'b011,
    SSRL_DRV_HOLD    = 3'b100
  } ssrl_drv_t;

endpackage

/* File: rtl/ssrl_relay_logic.sv */
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module ssrl_relay_logic #(
  parameter int unsigned TICK_CYCLES    = ssrl_pkg::TICK_CYCLES_DEF,
  parameter int unsigned HS_DELAY_TICKS = ssrl_pkg::HS_DELAY_TICKS
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic [6:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic signed [15:0] speed_act,
  input  wire logic signed [15:0] speed_set,
  input  wire logic signed [15:0] torque_act,
  input  wire logic signed [15:0] pos_err,
  input  wire logic               ramp_active,
  input  wire logic               accelerating,
  input  wire logic               positioning_done,
  input  wire logic               motor_temp_warn,
  input  wire logic               motor_temp_crit,
  input  wire logic               heatsink_trip,
  input  wire logic               star_delta_select,
  input  wire logic [15:0]        monitor_vars,
  input  wire logic               fine_axis_precision_mode,
  input  wire logic               ctrl_enable,
  input  wire logic               pulse_enable,
  input  wire logic               fast_stop_release,
  input  wire logic               fault_reset,
  output logic [5:0]              relay_out,
  output logic                    pulses_on,
  output logic                    brake_ramp,
  output logic                    brake_torque_limit,
  output logic                    fault,
  output logic                    irq
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || HS_DELAY_TICKS < 1 || HS_DELAY_TICKS > 65535)
  begin : g_bad_param
    $error("ssrl_relay_logic: timing parameter out of range");
  end

  typedef struct packed {
    logic [5:0][3:0]           func;
    logic [15:0]               speed_tol;
    logic [15:0]               torque_threshold;
    logic [15:0]               speed_min;
    logic [15:0]               speed_x;
    logic [15:0]               win1;
    logic [15:0]               win2;
    logic                      hold_mag;
    logic [3:0]                var_sel;
    logic [15:0]               mt_delay;
    logic [ssrl_pkg::IRQ_W-1:0] irq_stat;
    logic [ssrl_pkg::IRQ_W-1:0] irq_mask;
    logic                      fault_mt;
    logic                      fault_hs;
    ssrl_pkg::ssrl_drv_t       drv;
    logic                      ramp_done;
    logic [15:0]               prev_set;
    logic [15:0]               tick_cnt;
    logic [15:0]               mt_cnt;
    logic [15:0]               hs_cnt;
    logic                      prev_mt_warn;
    logic                      prev_hs;
    logic [5:0]                relay;
    logic                      ack;
    logic [31:0]               rdata;
  } ssrl_state_t;

  ssrl_state_t s;
  ssrl_state_t next_s;

  function automatic logic [15:0] ssrl_mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] ssrl_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  logic                      tick;
  logic                      at_set;
  logic [16:0]               diff;
  logic [15:0]               spd_mag;
  logic [ssrl_pkg::IRQ_W-1:0] ev;
  logic                      all_en;
  logic                      below_min;
  logic                      fn_ok;
  logic                      fn_val;
  logic [15:0]               wval;
  logic [31:0]               rd;
  logic [4:0]                widx;

  always_comb begin
    next_s = s;
    ev     = '0;
    fn_ok  = 1'b0;
    fn_val = 1'b0;
    rd     = '0;
    widx   = 5'(avs_address[6:2]);
    wval   = 16'h0000;

    // common timebase
    tick = (s.tick_cnt == 16'(TICK_CYCLES - 1));
    next_s.tick_cnt = tick ? 16'h0000 : 16'(s.tick_cnt + 16'h0001);

    spd_mag   = ssrl_mag(speed_act);
    diff      = 17'($signed({speed_act[15], speed_act}) - $signed({speed_set[15], speed_set}));
    at_set    = (diff[16] ? 17'(-diff) : diff) <= {1'b0, s.speed_tol};
    below_min = spd_mag < s.speed_min;

    // ramp complete latch: cleared by a new setpoint only
    next_s.prev_set = speed_set;
    if (speed_set != s.prev_set) begin
      next_s.ramp_done = 1'b0;
    end else if (!ramp_active && at_set) begin
      next_s.ramp_done = 1'b1;
    end

    // motor overtemperature delay
    if (!motor_temp_crit) begin
      next_s.mt_cnt = 16'h0000;
    end else if (s.mt_cnt >= s.mt_delay) begin
      ev[ssrl_pkg::IRQ_MT_FAULT] = !s.fault_mt;
    end else if (tick) begin
      next_s.mt_cnt = 16'(s.mt_cnt + 16'h0001);
    end

    // heatsink shutdown delay
    if (!heatsink_trip) begin
      next_s.hs_cnt = 16'h0000;
    end else if (s.hs_cnt >= 16'(HS_DELAY_TICKS)) begin
      ev[ssrl_pkg::IRQ_HS_FAULT] = !s.fault_hs;
    end else if (tick) begin
      next_s.hs_cnt = 16'(s.hs_cnt + 16'h0001);
    end

    next_s.prev_mt_warn = motor_temp_warn;
    next_s.prev_hs      = heatsink_trip;
    ev[ssrl_pkg::IRQ_MT_WARN] = motor_temp_warn && !s.prev_mt_warn;
    ev[ssrl_pkg::IRQ_HS_WARN] = heatsink_trip && !s.prev_hs;

    // fault reset, set wins over clear
    if (fault_reset && !ctrl_enable) begin
      if (!motor_temp_crit) begin
        next_s.fault_mt = 1'b0;
      end
      if (!heatsink_trip) begin
        next_s.fault_hs = 1'b0;
      end
    end
    if (ev[ssrl_pkg::IRQ_MT_FAULT]) begin
      next_s.fault_mt = 1'b1;
    end
    if (ev[ssrl_pkg::IRQ_HS_FAULT]) begin
      next_s.fault_hs = 1'b1;
    end

    // drive enable sequencing
    all_en = ctrl_enable && pulse_enable && fast_stop_release;
    unique case (s.drv)
      ssrl_pkg::SSRL_DRV_OFF: begin
        if (all_en && !s.fault_mt && !s.fault_hs) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_RUN;
        end
      end
      ssrl_pkg::SSRL_DRV_RUN: begin
        if (!fast_stop_release) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_TQ_BR;
        end else if (!ctrl_enable) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_RAMP_BR;
        end
      end
      ssrl_pkg::SSRL_DRV_RAMP_BR: begin
        if (!fast_stop_release) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_TQ_BR;
        end else if (below_min) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_OFF;
        end
      end
      ssrl_pkg::SSRL_DRV_TQ_BR: begin
        if (below_min) begin
          next_s.drv = s.hold_mag ? ssrl_pkg::SSRL_DRV_HOLD
                                  : ssrl_pkg::SSRL_DRV_OFF;
        end
      end
      ssrl_pkg::SSRL_DRV_HOLD: begin
        if (!ctrl_enable) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_OFF;
        end else if (fast_stop_release) begin
          next_s.drv = ssrl_pkg::SSRL_DRV_RUN;
        end
      end
      default: next_s.drv = ssrl_pkg::SSRL_DRV_OFF;
    endcase
    if (!pulse_enable || s.fault_mt || s.fault_hs) begin
      next_s.drv = ssrl_pkg::SSRL_DRV_OFF;
    end

    // relay function selection
    for (int i = 0; i < ssrl_pkg::NUM_RELAYS; i++) begin
      fn_ok  = 1'b1;
      fn_val = 1'b0;
      unique case (s.func[i])
        ssrl_pkg::SSRL_FN_RAMP:    fn_val = s.ramp_done;
        ssrl_pkg::SSRL_FN_AT_SET:  fn_val = at_set;
        ssrl_pkg::SSRL_FN_TORQUE:
          fn_val = (ssrl_mag(torque_act) < s.torque_threshold) && !accelerating;
        ssrl_pkg::SSRL_FN_NMIN: begin
          fn_ok  = fine_axis_precision_mode;
          fn_val = below_min;
        end
        ssrl_pkg::SSRL_FN_NX:      fn_val = spd_mag < s.speed_x;
        ssrl_pkg::SSRL_FN_MT_WARN: begin
          fn_ok  = fine_axis_precision_mode;
          fn_val = !motor_temp_warn;
        end
        ssrl_pkg::SSRL_FN_HS_WARN: begin
          fn_ok  = fine_axis_precision_mode;
          fn_val = !heatsink_trip;
        end
        ssrl_pkg::SSRL_FN_VAR: begin
          fn_ok  = fine_axis_precision_mode && (i < ssrl_pkg::NUM_VAR_RELAYS);
          fn_val = monitor_vars[s.var_sel];
        end
        ssrl_pkg::SSRL_FN_INPOS1:
          fn_val = positioning_done && (ssrl_mag(pos_err) <= s.win1);
        ssrl_pkg::SSRL_FN_INPOS2:
          fn_val = positioning_done && (ssrl_mag(pos_err) <= s.win2);
        ssrl_pkg::SSRL_FN_STAR:    fn_val = !star_delta_select;
        ssrl_pkg::SSRL_FN_DELTA:   fn_val = star_delta_select;
        default:                   fn_ok  = 1'b0;
      endcase
      next_s.relay[i] = fn_ok && fn_val;
    end

    // register read mux
    if (widx < 5'(ssrl_pkg::NUM_RELAYS)) begin
      rd[3:0] = s.func[widx[2:0]];
    end else begin
      unique case ({widx, 2'b00})
        ssrl_pkg::REG_SPEED_TOL:  rd[15:0] = s.speed_tol;
        ssrl_pkg::REG_TORQUE_THR: rd[15:0] = s.torque_threshold;
        ssrl_pkg::REG_SPEED_MIN:  rd[15:0] = s.speed_min;
        ssrl_pkg::REG_SPEED_X:    rd[15:0] = s.speed_x;
        ssrl_pkg::REG_INPOS_WIN1: rd[15:0] = s.win1;
        ssrl_pkg::REG_INPOS_WIN2: rd[15:0] = s.win2;
        ssrl_pkg::REG_CTRL:       rd[7:0]  = {s.var_sel, 3'b000, s.hold_mag};
        ssrl_pkg::REG_MT_DELAY:   rd[15:0] = s.mt_delay;
        ssrl_pkg::REG_STATUS:     rd[11:0] = {s.ramp_done, s.drv, s.fault_hs, s.fault_mt, s.relay};
        ssrl_pkg::REG_IRQ_STAT:   rd[3:0]  = s.irq_stat;
        ssrl_pkg::REG_IRQ_MASK:   rd[3:0]  = s.irq_mask;
        default:                  rd       = '0;
      endcase
    end

    // bus: capture in the first cycle, complete in the second
    next_s.ack = (avs_read || avs_write) && !s.ack;
    if ((avs_read || avs_write) && !s.ack) begin
      next_s.rdata = avs_read ? rd : 32'h0000_0000;
    end

    next_s.irq_stat = s.irq_stat | ev;
    if (s.ack && avs_read && ({widx, 2'b00} == ssrl_pkg::REG_IRQ_STAT)) begin
      // clears only bits that were returned; newer events survive
      next_s.irq_stat = (s.irq_stat & ~s.rdata[ssrl_pkg::IRQ_W-1:0]) | ev;
    end

    if (s.ack && avs_write) begin
      if (widx < 5'(ssrl_pkg::NUM_RELAYS)) begin
        wval = ssrl_merge({12'h000, s.func[widx[2:0]]}, avs_writedata, avs_byteenable);
        next_s.func[widx[2:0]] = wval[3:0];
      end else begin
        unique case ({widx, 2'b00})
          ssrl_pkg::REG_SPEED_TOL:
            next_s.speed_tol = ssrl_merge(s.speed_tol, avs_writedata, avs_byteenable);
          ssrl_pkg::REG_TORQUE_THR:
            next_s.torque_threshold = ssrl_merge(s.torque_threshold, avs_writedata,
                                                 avs_byteenable);
          ssrl_pkg::REG_SPEED_MIN:
            next_s.speed_min = ssrl_merge(s.speed_min, avs_writedata, avs_byteenable);
          ssrl_pkg::REG_SPEED_X:
            next_s.speed_x = ssrl_merge(s.speed_x, avs_writedata, avs_byteenable);
          ssrl_pkg::REG_INPOS_WIN1:
            next_s.win1 = ssrl_merge(s.win1, avs_writedata, avs_byteenable);
          ssrl_pkg::REG_INPOS_WIN2:
            next_s.win2 = ssrl_merge(s.win2, avs_writedata, avs_byteenable);
          ssrl_pkg::REG_CTRL: begin
            if (avs_byteenable[0]) begin
              next_s.hold_mag = avs_writedata[ssrl_pkg::CTRL_HOLD_BIT];
              next_s.var_sel  = avs_writedata[ssrl_pkg::CTRL_VSEL_LSB +: 4];
            end
          end
          ssrl_pkg::REG_MT_DELAY:
            next_s.mt_delay = ssrl_merge(s.mt_delay, avs_writedata, avs_byteenable);
          ssrl_pkg::REG_IRQ_MASK: begin
            if (avs_byteenable[0]) begin
              next_s.irq_mask = avs_writedata[ssrl_pkg::IRQ_W-1:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s                  <= '0;
      s.speed_tol        <= ssrl_pkg::RST_SPEED_TOL;
      s.torque_threshold <= ssrl_pkg::RST_TORQUE_THR;
      s.speed_min        <= ssrl_pkg::RST_SPEED_MIN;
      s.speed_x          <= ssrl_pkg::RST_SPEED_X;
      s.win1             <= ssrl_pkg::RST_INPOS_WIN;
      s.win2             <= ssrl_pkg::RST_INPOS_WIN;
      s.mt_delay         <= ssrl_pkg::RST_MT_DELAY;
      s.drv              <= ssrl_pkg::SSRL_DRV_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest    = (avs_read || avs_write) && !s.ack;
  assign avs_readdata       = s.rdata;
  assign relay_out          = s.relay;
  assign pulses_on          = (s.drv != ssrl_pkg::SSRL_DRV_OFF);
  assign brake_ramp         = (s.drv == ssrl_pkg::SSRL_DRV_RAMP_BR);
  assign brake_torque_limit = (s.drv == ssrl_pkg::SSRL_DRV_TQ_BR);
  assign fault              = s.fault_mt || s.fault_hs;
  assign irq                = |(s.irq_stat & s.irq_mask);

endmodule // ssrl_relay_logic

/* File: verif/ssrl_machine_ctl.sv */
`timescale 1ns/1ps
module ssrl_machine_ctl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run_cmd,
  input wire logic drop_ctrl,
  input wire logic drop_fast,
  input wire logic drop_pulse,
  input wire logic reset_req,
  output logic     ctrl_enable,
  output logic     pulse_enable,
  output logic     fast_stop_release,
  output logic     fault_reset
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_enable <= 1'b0;
      pulse_enable <= 1'b0;
      fast_stop_release <= 1'b0;
      fault_reset <= 1'b0;
    end else begin
      ctrl_enable <= run_cmd && !drop_ctrl;
      pulse_enable <= run_cmd && !drop_pulse;
      fast_stop_release <= run_cmd && !drop_fast;
      fault_reset <= reset_req && !ctrl_enable;
    end
  end
endmodule // ssrl_machine_ctl

/* File: verif/ssrl_relay_logic_asserts.sv */
`timescale 1ns/1ps
module ssrl_relay_logic_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        accelerating,
  input wire logic        motor_temp_warn,
  input wire logic        star_delta_select,
  input wire logic        fine_axis_precision_mode,
  input wire logic        ctrl_enable,
  input wire logic        pulse_enable,
  input wire logic        fast_stop_release,
  input wire logic [5:0]  relay_out,
  input wire logic        pulses_on,
  input wire logic        brake_ramp,
  input wire logic        brake_torque_limit,
  input wire logic        fault,
  input wire logic        irq
);
  logic [3:0] func_sh [6];

  // shadow of the function codes, updated on the completing write edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) func_sh[i] <= 4'h0;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address < 7'h18) begin
      func_sh[avs_address[4:2]] <= avs_writedata[3:0];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> relay_out == 6'h00 && !pulses_on && !fault && !irq)
    else $error("outputs active after reset");
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_power_all: assert property (
    $rose(pulses_on) |-> $past(ctrl_enable && pulse_enable && fast_stop_release))
    else $error("pulses on without all three enables");
  a_pulse_cut: assert property (!pulse_enable |=> !pulses_on)
    else $error("pulses stay on without pulse enable");
  a_fault_cut: assert property (fault |=> !pulses_on)
    else $error("pulses stay on with a fault");
  a_ramp_brake: assert property (
    pulses_on && !brake_ramp && !brake_torque_limit && !ctrl_enable
    && pulse_enable && fast_stop_release && !fault |=> brake_ramp || !pulses_on)
    else $error("no ramp braking after enable removal");
  a_star_out: assert property (
    func_sh[0] == 4'hB |=> relay_out[0] == !$past(star_delta_select))
    else $error("star relay wrong");
  a_delta_out: assert property (
    func_sh[0] == 4'hC |=> relay_out[0] == $past(star_delta_select))
    else $error("delta relay wrong");
  a_free_code: assert property (func_sh[0] > 4'hC |=> !relay_out[0])
    else $error("unassigned code drives relay");
  a_fine_only: assert property (
    !fine_axis_precision_mode && func_sh[0] inside {4'h4, 4'h6, 4'h7, 4'h8} |=> !relay_out[0])
    else $error("fine mode code active outside fine mode");
  a_accel_mute: assert property (func_sh[0] == 4'h3 && accelerating |=> !relay_out[0])
    else $error("torque relay on while accelerating");
  a_var_two: assert property (func_sh[2] == 4'h8 |=> !relay_out[2])
    else $error("variable monitor on third relay");
  a_warn_drop: assert property (func_sh[0] == 4'h6 && motor_temp_warn |=> !relay_out[0])
    else $error("motor prewarn relay stays in");
endmodule // ssrl_relay_logic_asserts

bind ssrl_relay_logic ssrl_relay_logic_asserts u_chk (
  .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .accelerating, .motor_temp_warn, .star_delta_select,
  .fine_axis_precision_mode, .ctrl_enable, .pulse_enable, .fast_stop_release, .relay_out,
  .pulses_on, .brake_ramp, .brake_torque_limit, .fault, .irq);

/* File: verif/ssrl_relay_logic_tb.sv */
`timescale 1ns/1ps
module ssrl_relay_logic_tb;
  logic               ref_clk, rst, avs_read, avs_write, avs_waitrequest, ramp_active;
  logic               accelerating, positioning_done, motor_temp_warn, motor_temp_crit;
  logic               heatsink_trip, star_delta_select, fine_axis_precision_mode, irq;
  logic               ctrl_enable, pulse_enable, fast_stop_release, fault_reset, pulses_on;
  logic               brake_ramp, brake_torque_limit, fault, mc_run, mc_dc, mc_df, mc_dp, mc_rr;
  logic [6:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata, q;
  logic [3:0]         avs_byteenable;
  logic signed [15:0] speed_act, speed_set, torque_act, pos_err;
  logic [15:0]        monitor_vars;
  logic [5:0]         relay_out;
  int                 bad_count, cmp_count, cyc;

  ssrl_relay_logic #(.TICK_CYCLES(4), .HS_DELAY_TICKS(10)) uut (
    .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .speed_act, .speed_set, .torque_act, .pos_err,
    .ramp_active, .accelerating, .positioning_done, .motor_temp_warn, .motor_temp_crit,
    .heatsink_trip, .star_delta_select, .monitor_vars, .fine_axis_precision_mode,
    .ctrl_enable, .pulse_enable, .fast_stop_release, .fault_reset, .relay_out, .pulses_on,
    .brake_ramp, .brake_torque_limit, .fault, .irq);
  ssrl_machine_ctl u_mc (.ref_clk(ref_clk), .rst(rst), .run_cmd(mc_run), .drop_ctrl(mc_dc),
    .drop_fast(mc_df), .drop_pulse(mc_dp), .reset_req(mc_rr), .ctrl_enable(ctrl_enable),
    .pulse_enable(pulse_enable), .fast_stop_release(fast_stop_release),
    .fault_reset(fault_reset));

  always #25 ref_clk = !ref_clk;

  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic waitn(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic rel(input logic [3:0] c, input logic e);
    bus(1'b1, 7'h00, {28'h0, c});
    waitn(3);
    chk(relay_out[0], e);
  endtask

  task automatic t_regs();
    rdc(7'h18, 32'h10);
    rdc(7'h1C, 32'h100);
    rdc(7'h34, 32'h3E8);
    rdc(7'h7C, 32'h0);
    bus(1'b1, 7'h14, 32'h5);
    rdc(7'h14, 32'h5);
  endtask

  task automatic t_codes();
    rel(4'hB, 1'b1);
    rel(4'hC, 1'b0);
    for (int c = 13; c < 16; c++) rel(c[3:0], 1'b0);
    @(posedge ref_clk);
    speed_act <= 16'sd2;
    rel(4'h4, 1'b0);
    @(posedge ref_clk);
    fine_axis_precision_mode <= 1'b1;
    rel(4'h4, 1'b1);
    @(posedge ref_clk);
    speed_act <= -16'sd50;
    rel(4'h5, 1'b1);
    rel(4'h4, 1'b0);
    @(posedge ref_clk);
    torque_act <= -16'sd16;
    accelerating <= 1'b1;
    rel(4'h3, 1'b0);
    @(posedge ref_clk);
    accelerating <= 1'b0;
    rel(4'h3, 1'b1);
    @(posedge ref_clk);
    positioning_done <= 1'b1;
    pos_err <= -16'sd4;
    rel(4'h9, 1'b1);
    @(posedge ref_clk);
    pos_err <= 16'sd5;
    rel(4'hA, 1'b0);
    @(posedge ref_clk);
    motor_temp_warn <= 1'b1;
    rel(4'h6, 1'b0);
    @(posedge ref_clk);
    motor_temp_warn <= 1'b0;
    monitor_vars <= 16'h0008;
    rel(4'h6, 1'b1);
    bus(1'b1, 7'h30, 32'h30);
    bus(1'b1, 7'h08, 32'h8);
    rel(4'h8, 1'b1);
    chk(relay_out[2], 1'b0);
    @(posedge ref_clk);
    speed_set <= 16'sd100;
    speed_act <= 16'sd100;
    rel(4'h2, 1'b1);
    @(posedge ref_clk);
    speed_act <= 16'sd150;
    waitn(3);
    chk(relay_out[0], 1'b0);
    rel(4'h1, 1'b1);
    @(posedge ref_clk);
    ramp_active <= 1'b1;
    speed_set <= 16'sd150;
    waitn(3);
    chk(relay_out[0], 1'b0);
    @(posedge ref_clk);
    ramp_active <= 1'b0;
    waitn(3);
    chk(relay_out[0], 1'b1);
  endtask

  task automatic t_power();
    @(posedge ref_clk);
    mc_run <= 1'b1;
    mc_df <= 1'b1;
    waitn(4);
    chk(pulses_on, 1'b0);
    @(posedge ref_clk);
    mc_df <= 1'b0;
    waitn(4);
    chk(pulses_on, 1'b1);
    @(posedge ref_clk);
    mc_dp <= 1'b1;
    waitn(4);
    chk(pulses_on, 1'b0);
    @(posedge ref_clk);
    mc_dp <= 1'b0;
    waitn(4);
    @(posedge ref_clk);
    mc_dc <= 1'b1;
    waitn(3);
    chk(brake_ramp, 1'b1);
    chk(pulses_on, 1'b1);
    @(posedge ref_clk);
    speed_act <= 16'sd3;
    waitn(3);
    chk(pulses_on, 1'b0);
    @(posedge ref_clk);
    mc_run <= 1'b0;
    mc_dc <= 1'b0;
  endtask

  task automatic t_brake();
    for (int h = 0; h < 2; h++) begin
      bus(1'b1, 7'h30, {31'h0, h[0]});
      @(posedge ref_clk);
      speed_act <= 16'sd100;
      mc_run <= 1'b1;
      waitn(4);
      @(posedge ref_clk);
      mc_df <= 1'b1;
      waitn(3);
      chk(brake_torque_limit, 1'b1);
      @(posedge ref_clk);
      speed_act <= 16'sd3;
      waitn(3);
      chk(pulses_on, h[0]);
      @(posedge ref_clk);
      mc_run <= 1'b0;
      mc_df <= 1'b0;
      waitn(6);
    end
  endtask

  task automatic t_heat();
    bus(1'b0, 7'h3C, 32'h0);
    bus(1'b1, 7'h40, 32'h2);
    bus(1'b1, 7'h00, 32'h7);
    @(posedge ref_clk);
    mc_run <= 1'b1;
    waitn(4);
    chk(relay_out[0], 1'b1);
    chk(irq, 1'b0);
    @(posedge ref_clk);
    heatsink_trip <= 1'b1;
    waitn(3);
    chk(relay_out[0], 1'b0);
    chk(irq, 1'b1);
    waitn(30);
    chk(fault, 1'b0);
    waitn(20);
    chk(fault, 1'b1);
    chk(pulses_on, 1'b0);
    rdc(7'h3C, 32'hA);
    rdc(7'h3C, 32'h0);
    chk(irq, 1'b0);
    @(posedge ref_clk);
    mc_run <= 1'b0;
    mc_rr <= 1'b1;
    waitn(4);
    chk(fault, 1'b1);
    @(posedge ref_clk);
    heatsink_trip <= 1'b0;
    waitn(4);
    chk(fault, 1'b0);
    bus(1'b1, 7'h34, 32'h2);
    @(posedge ref_clk);
    motor_temp_crit <= 1'b1;
    waitn(3);
    chk(fault, 1'b0);
    waitn(8);
    chk(fault, 1'b1);
    @(posedge ref_clk);
    motor_temp_crit <= 1'b0;
    waitn(3);
    chk(fault, 1'b0);
  endtask

  initial begin
    {ref_clk, avs_read, avs_write, ramp_active, accelerating, positioning_done} = '0;
    {motor_temp_warn, motor_temp_crit, heatsink_trip, star_delta_select} = '0;
    {fine_axis_precision_mode, mc_run, mc_dc, mc_df, mc_dp, mc_rr} = '0;
    {speed_act, speed_set, torque_act, pos_err, monitor_vars} = '0;
    {avs_address, avs_writedata, bad_count, cmp_count, cyc} = '0;
    avs_byteenable = 4'hF;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_codes();
    t_power();
    t_brake();
    t_heat();
    close_out();
  end
endmodule // ssrl_relay_logic_tb
